//--- src/sysref_aperture_calibration.v
// Summary of operation
// - averaging code 0..3 selects 4, 16, 64 or 256 averages.
// - larger averaging code runs longer and smooths the delay result.
// - accumulation code 0..3 selects 4, 16, 64 or 256 cycles each.
// - larger accumulation code runs longer, allows longer sysref periods.
// - calibration ends within 256 x 19 x 4^(avg+acc) device clocks.
// - config register resets to 0x05 with reserved bits zero.
// - complete flag reads 1 only while enabled and finished.
// - status low 17 bits return the computed delay value.
// - manual register: coarse byte 15-8, fine byte 7-0, resets zero.
// - enable rising starts calibration; enabled ignores manual delay.
// - manual bit 16 inverts the sample clock.
//
// The APB slave port was decided locally.
`include "sysref_cal_defines.vh"

module sysref_aperture_calibration
#(
  parameter CAL_BOUND_BASE = `CAL_BOUND_BASE
)
(
  // clock and reset
  input  wire        mclk_in,
  input  wire        resetn_in,
  // apb slave
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output reg         pready_out,
  output reg         pslverr_out,
  // timing reference
  input  wire        sysref_in,
  // clock delay path
  output reg  [16:0] delay_value_out,
  output reg         sample_clock_invert_out
);

  // ----------------------------------------------------------------
  // sequencer states and helpers
  // ----------------------------------------------------------------
  localparam ST_IDLE  = 2'd0;
  localparam ST_WAIT  = 2'd1;
  localparam ST_ACCUM = 2'd2;
  localparam ST_DONE  = 2'd3;

  // log2 of a power-of-four count selected by a two-bit code
  function [4:0] log_len;
    input [1:0] code;
    begin
      log_len = {2'b00, code, 1'b0} + 5'd2;
    end
  endfunction

  // ----------------------------------------------------------------
  // registers and wires
  // ----------------------------------------------------------------
  reg        cal_enable_r;
  reg [7:0]  cal_config_r;
  reg [23:0] aperture_delay_manual_r;
  reg [1:0]  state_r;
  reg [1:0]  state_nxt;
  reg        calibration_complete_r;
  reg        cal_fault_r;
  reg [16:0] computed_delay_value_r;
  reg [16:0] high_sum_r;
  reg [8:0]  avg_left_r;
  reg [8:0]  acc_left_r;
  reg [31:0] bound_count_r;
  reg [1:0]  run_avg_r;
  reg [1:0]  run_acc_r;
  reg        sysref_s_r;

  wire       wr_en;
  wire       rd_setup;
  wire [9:0] reg_idx;
  wire       start;
  wire       edge_seen;
  wire       overrun;
  wire [4:0] avg_shift;
  wire [4:0] acc_shift;
  wire [31:0] bound_limit;
  wire       bound_hit;
  wire [16:0] result;
  wire       abort;
  wire [31:0] status_word;

  // ----------------------------------------------------------------
  // bus decode and datapath
  // ----------------------------------------------------------------
  assign reg_idx  = paddr_in[11:2];
  assign wr_en    = psel_in & penable_in & pwrite_in & pready_out;
  assign rd_setup = psel_in & ~penable_in;
  // writing one while already enabled does not restart a pass
  assign start    = wr_en & (reg_idx == `IDX_CAL_ENABLE) & pwdata_in[0] & ~cal_enable_r;

  // config is sampled at start so later writes cannot disturb a running pass
  assign avg_shift   = log_len(run_avg_r);
  assign acc_shift   = log_len(run_acc_r);
  assign bound_limit = CAL_BOUND_BASE << (avg_shift + acc_shift - 5'd4);
  // a pass that never sees enough edges must still end
  assign bound_hit   = (bound_count_r >= bound_limit);
  // mean high fraction scaled to 16 fractional bits
  assign result = high_sum_r << (`DELAY_FRAC_BITS - avg_shift - acc_shift);
  // an overrun or a blown time bound drops the pass and sets the fault flag
  assign abort  = (state_r == ST_WAIT || state_r == ST_ACCUM) & (overrun | bound_hit);
  // status word: complete flag above the computed delay
  assign status_word = {14'h0000, cal_enable_r & calibration_complete_r,
                        computed_delay_value_r};

  // ----------------------------------------------------------------
  // sysref period check
  // ----------------------------------------------------------------
  // period count restarts whenever the sequencer is idle
  sysref_period_monitor u_monitor
  (
    .mclk_in     (mclk_in),
    .resetn_in   (resetn_in),
    .clear_in    (state_r == ST_IDLE),
    .acc_code_in (run_acc_r),
    .sysref_in   (sysref_in),
    .edge_out    (edge_seen),
    .overrun_out (overrun)
  );

  // ----------------------------------------------------------------
  // calibration sequencer
  // ----------------------------------------------------------------
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        state_nxt = ST_IDLE;
      ST_WAIT:
        if (edge_seen)
          state_nxt = ST_ACCUM;
      ST_ACCUM:
        if (acc_left_r == 9'd1)
          state_nxt = (avg_left_r == 9'd1) ? ST_DONE : ST_WAIT;
      ST_DONE:
        state_nxt = ST_DONE;
      default:
        state_nxt = ST_IDLE;
    endcase
    if (abort)
      state_nxt = ST_IDLE;
    if (!cal_enable_r)
      state_nxt = ST_IDLE;
    if (start)
      state_nxt = ST_WAIT;
  end

  // ----------------------------------------------------------------
  // sequencer state and accumulation
  // ----------------------------------------------------------------
  always @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_r                <= ST_IDLE;
      calibration_complete_r <= 1'b0;
      cal_fault_r            <= 1'b0;
      computed_delay_value_r <= 17'h00000;
      high_sum_r             <= 17'h00000;
      avg_left_r             <= 9'h000;
      acc_left_r             <= 9'h000;
      bound_count_r          <= 32'h00000000;
      run_avg_r              <= 2'h0;
      run_acc_r              <= 2'h0;
      sysref_s_r             <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      sysref_s_r <= sysref_in;
      if (start)
      begin
        run_avg_r              <= cal_config_r[`CFG_AVG_HI:`CFG_AVG_LO];
        run_acc_r              <= cal_config_r[`CFG_ACC_HI:`CFG_ACC_LO];
        avg_left_r             <= 9'h001 << log_len(cal_config_r[`CFG_AVG_HI:`CFG_AVG_LO]);
        acc_left_r             <= 9'h001 << log_len(cal_config_r[`CFG_ACC_HI:`CFG_ACC_LO]);
        high_sum_r             <= 17'h00000;
        bound_count_r          <= 32'h00000000;
        calibration_complete_r <= 1'b0;
        cal_fault_r            <= 1'b0;
      end
      else
      begin
        if (state_r == ST_WAIT || state_r == ST_ACCUM)
          bound_count_r <= bound_count_r + 32'h00000001;
        if (abort)
          cal_fault_r <= 1'b1;
        if (state_r == ST_ACCUM)
        begin
          high_sum_r <= high_sum_r + {16'h0000, sysref_s_r};
          if (acc_left_r == 9'd1)
          begin
            acc_left_r <= 9'h001 << acc_shift;
            avg_left_r <= avg_left_r - 9'd1;
          end
          else
            acc_left_r <= acc_left_r - 9'd1;
        end
        if (state_r == ST_ACCUM && state_nxt == ST_DONE)
        begin
          computed_delay_value_r <= result;
          calibration_complete_r <= 1'b1;
        end
        if (!cal_enable_r)
          calibration_complete_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      cal_enable_r            <= 1'b0;
      cal_config_r            <= `CFG_RESET;
      aperture_delay_manual_r <= `MANUAL_RESET;
    end
    else if (wr_en)
    begin
      case (reg_idx)
        `IDX_CAL_ENABLE:
          cal_enable_r <= pwdata_in[0];
        `IDX_CAL_CONFIG:
          cal_config_r <= {4'h0, pwdata_in[3:0]};
        `IDX_DELAY_MANUAL:
          aperture_delay_manual_r <= pwdata_in[23:0] & `MANUAL_WR_MASK;
        // status and fault are read only; writes there are dropped
        default:
          cal_enable_r <= cal_enable_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read data, captured in the setup cycle for a zero-wait access
  // ----------------------------------------------------------------
  always @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      prdata_out  <= 32'h00000000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end
    else
    begin
      pready_out <= 1'b1;
      if (rd_setup)
      begin
        pslverr_out <= 1'b0;
        prdata_out  <= 32'h00000000;
        case (reg_idx)
          `IDX_CAL_ENABLE:
            prdata_out <= {31'h00000000, cal_enable_r};
          `IDX_CAL_CONFIG:
            prdata_out <= {24'h000000, cal_config_r};
          `IDX_CAL_STATUS:
            prdata_out <= status_word;
          `IDX_DELAY_MANUAL:
            prdata_out <= {8'h00, aperture_delay_manual_r};
          `IDX_CAL_FAULT:
            prdata_out <= {31'h00000000, cal_fault_r};
          default:
            pslverr_out <= 1'b1;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // delay path: calibration owns the delay value while enabled; invert always follows manual bit 16
  // ----------------------------------------------------------------
  always @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      delay_value_out         <= 17'h00000;
      sample_clock_invert_out <= 1'b0;
    end
    else
    begin
      sample_clock_invert_out <= aperture_delay_manual_r[`MANUAL_INV_BIT];
      if (!cal_enable_r)
        delay_value_out <= {1'b0, aperture_delay_manual_r[15:0]};
      // a failed pass leaves the last applied value in place
      else if (calibration_complete_r)
        delay_value_out <= computed_delay_value_r;
    end
  end

endmodule // sysref_aperture_calibration

//--- src/sysref_cal_defines.vh
`ifndef SYSREF_CAL_DEFINES_VH
`define SYSREF_CAL_DEFINES_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_CAL_ENABLE      10'h2b0
`define IDX_CAL_CONFIG      10'h2b1
`define IDX_CAL_STATUS      10'h2b2
`define IDX_DELAY_MANUAL    10'h2b5
`define IDX_CAL_FAULT       10'h2ba

// ----------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------
`define CFG_AVG_HI          3
`define CFG_AVG_LO          2
`define CFG_ACC_HI          1
`define CFG_ACC_LO          0
`define CFG_RESET           8'h05
`define MANUAL_RESET        24'h000000
`define MANUAL_INV_BIT      16
`define MANUAL_WR_MASK      24'h01ffff
`define STATUS_DONE_BIT     17

// ----------------------------------------------------------------
// longest sysref period per accumulation code, device clocks
// ----------------------------------------------------------------
`define MAX_PERIOD_0        16'd85
`define MAX_PERIOD_1        16'd1100
`define MAX_PERIOD_2        16'd5200
`define MAX_PERIOD_3        16'd21580

// ----------------------------------------------------------------
// calibration time bound: 256 x 19 x 4^(avg + acc)
// ----------------------------------------------------------------
`define CAL_BOUND_BASE      4864
`define DELAY_FRAC_BITS     5'd16

`endif

//--- src/sysref_period_monitor.v
`include "sysref_cal_defines.vh"

module sysref_period_monitor
(
  // clock and reset
  input  wire        mclk_in,
  input  wire        resetn_in,
  // control
  input  wire        clear_in,
  input  wire [1:0]  acc_code_in,
  input  wire        sysref_in,
  // results
  output reg         edge_out,
  output reg         overrun_out
);

  reg        sysref_d_r;
  reg [15:0] count_r;
  reg [15:0] limit;

  always @*
  begin
    case (acc_code_in)
      2'd0:    limit = `MAX_PERIOD_0;
      2'd1:    limit = `MAX_PERIOD_1;
      2'd2:    limit = `MAX_PERIOD_2;
      default: limit = `MAX_PERIOD_3;
    endcase
  end

  // ----------------------------------------------------------------
  // period count between rising edges
  // ----------------------------------------------------------------
  always @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      sysref_d_r  <= 1'b0;
      count_r     <= 16'h0000;
      edge_out    <= 1'b0;
      overrun_out <= 1'b0;
    end
    else
    begin
      sysref_d_r <= sysref_in;
      edge_out   <= sysref_in & ~sysref_d_r & ~clear_in;
      if (clear_in || (sysref_in && !sysref_d_r))
        count_r <= 16'h0000;
      else if (count_r != 16'hffff)
        count_r <= count_r + 16'h0001;
      // too slow a sysref can never calibrate; the count peaks at period - 1
      overrun_out <= ~clear_in & (count_r >= limit);
    end
  end

endmodule // sysref_period_monitor

//--- tb/sysref_source.sv
module sysref_source
(
  input  logic        mclk_in,
  input  logic        resetn_in,
  input  logic [15:0] period_in,
  output logic        sysref_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_r;
  // rising edge every period_in cycles; the period is the only knob
  always @(posedge mclk_in or negedge resetn_in)
    if (!resetn_in)
    begin
      cnt_r      <= 16'h0;
      sysref_out <= 1'b0;
    end
    else
    begin
      cnt_r      <= (cnt_r >= period_in - 16'h1) ? 16'h0 : cnt_r + 16'h1;
      sysref_out <= cnt_r < (period_in >> 1);
    end
endmodule // sysref_source

//--- tb/sysref_cal_checker.sv
`include "sysref_cal_defines.vh"
module sysref_cal_checker #(parameter CAL_BOUND_BASE = 4864)
(
  input logic        mclk_in,
  input logic        resetn_in,
  input logic        psel_in,
  input logic        penable_in,
  input logic        pwrite_in,
  input logic [11:0] paddr_in,
  input logic [31:0] pwdata_in,
  input logic [31:0] prdata_out,
  input logic        pready_out,
  input logic        pslverr_out,
  input logic        sysref_in,
  input logic [16:0] delay_value_out,
  input logic        sample_clock_invert_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       en_r;
  wire  [9:0] idx = paddr_in[11:2];
  wire        rd  = psel_in && penable_in && !pwrite_in;
  wire        wr  = psel_in && penable_in && pwrite_in && pready_out;
  wire        map = idx == `IDX_CAL_ENABLE || idx == `IDX_CAL_CONFIG || idx == `IDX_CAL_STATUS
                    || idx == `IDX_DELAY_MANUAL || idx == `IDX_CAL_FAULT;
  // shadow of the enable bit, only visible through bus writes
  always @(posedge mclk_in or negedge resetn_in)
    if (!resetn_in)
      en_r <= 1'b0;
    else if (wr && idx == `IDX_CAL_ENABLE)
      en_r <= pwdata_in[0];
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  unmapped_err_a: assert property (psel_in && penable_in && !map |-> pslverr_out)
    else $error("unmapped access without error");
  cfg_rsvd_a: assert property (rd && idx == `IDX_CAL_CONFIG |-> prdata_out[31:4] == 28'h0)
    else $error("config reserved bits set");
  man_rsvd_a: assert property (rd && idx == `IDX_DELAY_MANUAL |-> prdata_out[31:17] == 15'h0)
    else $error("manual reserved bits set");
  stat_rsvd_a: assert property (rd && idx == `IDX_CAL_STATUS |-> prdata_out[31:18] == 14'h0)
    else $error("status reserved bits set");
  idle_done_a: assert property (rd && idx == `IDX_CAL_STATUS && !en_r |-> !prdata_out[17])
    else $error("complete while disabled");
  inv_copy_a: assert property (wr && idx == `IDX_DELAY_MANUAL
    |-> ##2 sample_clock_invert_out == $past(pwdata_in[16], 2)) else $error("invert not applied");
  manual_path_a: assert property (wr && idx == `IDX_DELAY_MANUAL && !en_r
    |-> ##2 delay_value_out == {1'b0, $past(pwdata_in[15:0], 2)}) else $error("manual delay lost");
  result_apply_a: assert property (rd && idx == `IDX_CAL_STATUS && en_r && prdata_out[17]
    |-> delay_value_out == prdata_out[16:0]) else $error("computed delay not applied");
endmodule // sysref_cal_checker
bind sysref_aperture_calibration sysref_cal_checker #(.CAL_BOUND_BASE(CAL_BOUND_BASE)) i_chk (
  .mclk_in(mclk_in), .resetn_in(resetn_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .sysref_in(sysref_in),
  .delay_value_out(delay_value_out), .sample_clock_invert_out(sample_clock_invert_out));

//--- tb/test_sysref_aperture_calibration.sv
`include "sysref_cal_defines.vh"
module test_sysref_aperture_calibration;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_in = 0, resetn_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0, perr;
  logic [11:0] paddr_in = 12'h0;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rdat;
  logic        pready_out, pslverr_out, sample_clock_invert_out, sysref;
  logic [16:0] delay_value_out;
  logic [15:0] period = 16'd85;
  int          error_cnt = 0, comparisons = 0, cycles = 0, t_a, t_b, t_c, t_d;
  sysref_aperture_calibration i_dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .sysref_in(sysref), .delay_value_out(delay_value_out),
    .sample_clock_invert_out(sample_clock_invert_out));
  sysref_source i_src (.mclk_in(mclk_in), .resetn_in(resetn_in), .period_in(period),
    .sysref_out(sysref));
  always #2.5 mclk_in = ~mclk_in;
  // the whole run needs about a quarter of this
  always @(posedge mclk_in)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      error_cnt++;
      close_out();
    end
  end
  // ----------------------------------------------------------------
  // bus and compare helpers
  // ----------------------------------------------------------------
  task automatic close_out;
    if (error_cnt == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] wd);
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= w;
    paddr_in   <= {idx, 2'b00};
    pwdata_in  <= wd;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    do @(posedge mclk_in); while (pready_out !== 1'b1);
    if (!w)
      rdat = prdata_out;
    perr = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic rchk(input string nm, input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(nm, exp, rdat);
    chk("pslverr", 32'h0, {31'h0, perr});
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rchk("config", `IDX_CAL_CONFIG, 32'h05);
    rchk("manual", `IDX_DELAY_MANUAL, 32'h0);
    apb(1'b0, `IDX_CAL_STATUS, 32'h0);
    chk("complete", 32'h0, {31'h0, rdat[17]});
    apb(1'b0, 10'h3ff, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, perr});
    chk("unmapped data", 32'h0, rdat);
    apb(1'b1, `IDX_DELAY_MANUAL, 32'hffffffff);
    rchk("manual", `IDX_DELAY_MANUAL, 32'h01ffff);
    chk("invert", 32'h1, {31'h0, sample_clock_invert_out});
    chk("delay", 32'h0ffff, {15'h0, delay_value_out});
    apb(1'b1, `IDX_DELAY_MANUAL, 32'h0000a5c3);
    @(posedge mclk_in);
    chk("invert", 32'h0, {31'h0, sample_clock_invert_out});
    chk("delay", 32'h0a5c3, {15'h0, delay_value_out});
    apb(1'b1, `IDX_CAL_CONFIG, 32'hffffffff);
    rchk("config", `IDX_CAL_CONFIG, 32'h0f);
  endtask
  task automatic cal(input logic [1:0] avg, input logic [1:0] acc, input logic [15:0] per,
                     output int t);
    int t0, e;
    e = avg;
    e += acc;
    period <= per;
    apb(1'b1, `IDX_CAL_CONFIG, {28'h0, avg, acc});
    apb(1'b1, `IDX_CAL_ENABLE, 32'h0);
    apb(1'b1, `IDX_CAL_ENABLE, 32'h1);
    t0 = cycles;
    rdat = 32'h0;
    while (rdat[17] !== 1'b1 && cycles - t0 < (4864 << (2 * e))) apb(1'b0, `IDX_CAL_STATUS, 0);
    t = cycles - t0;
    chk("complete", 32'h1, {31'h0, rdat[17]});
    chk("applied", {15'h0, rdat[16:0]}, {15'h0, delay_value_out});
    apb(1'b1, `IDX_DELAY_MANUAL, 32'h00001234);
    chk("held", {15'h0, rdat[16:0]}, {15'h0, delay_value_out});
  endtask
  task automatic t_fault;
    int t0;
    period <= 16'd86;
    apb(1'b1, `IDX_CAL_CONFIG, 32'h0);
    apb(1'b1, `IDX_CAL_ENABLE, 32'h0);
    apb(1'b1, `IDX_CAL_ENABLE, 32'h1);
    t0 = cycles;
    rdat = 32'h0;
    while (rdat[0] !== 1'b1 && cycles - t0 < 4864) apb(1'b0, `IDX_CAL_FAULT, 0);
    chk("fault", 32'h1, {31'h0, rdat[0]});
    apb(1'b0, `IDX_CAL_STATUS, 32'h0);
    chk("complete", 32'h0, {31'h0, rdat[17]});
  endtask
  initial
  begin
    repeat (8) @(posedge mclk_in);
    resetn_in <= 1'b1;
    @(posedge mclk_in);
    t_regs;
    cal(2'd0, 2'd0, 16'd85, t_a);
    cal(2'd1, 2'd0, 16'd85, t_b);
    cal(2'd0, 2'd1, 16'd1100, t_c);
    cal(2'd3, 2'd0, 16'd8, t_d);
    cal(2'd2, 2'd2, 16'd85, t_d);
    cal(2'd0, 2'd3, 16'd300, t_d);
    apb(1'b1, `IDX_CAL_ENABLE, 32'h0);
    apb(1'b0, `IDX_CAL_STATUS, 32'h0);
    chk("complete", 32'h0, {31'h0, rdat[17]});
    chk("avg longer", 32'h1, {31'h0, t_b > 3 * t_a});
    chk("acc longer", 32'h1, {31'h0, t_c > 3 * t_a});
    t_fault;
    close_out;
  end
endmodule // test_sysref_aperture_calibration
